// file: pkg/crd_cfg.svh
`ifndef CRD_CFG_SVH
`define CRD_CFG_SVH
`define CRD_DEV_SEL      8'h50
`define CRD_OP_IO        4'hb
`define CRD_CLS_LOAD     4'h0
`define CRD_CLS_SENSE    4'h4
`define CRD_CLS_CTL      4'h8
`define CRD_CLS_BRANCH   4'hd
`define CRD_BR_TAIL      4'h0
`define CRD_BR_UCHK      4'h0
`define CRD_BR_NO_UCHK   4'h1
`define CRD_BR_DIAG_OK   4'h4
`define CRD_BR_DIAG_BAD  4'h6
`define CRD_LD_DIAG_SET  4'h0
`define CRD_LD_DIAG_CLR  4'h1
`define CRD_LD_IRQ_CLR   4'h3
`define CRD_LD_IRQ_SET   4'h4
`define CRD_LD_BUS_IN    4'h5
`define CRD_LD_IRQ_BLOCK 4'h6
`define CRD_LD_IRQ_ALLOW 4'h7
`define CRD_SN_DATA      4'h0
`define CRD_SN_STAT1     4'h1
`define CRD_SN_STAT2     4'h2
`define CRD_SN_STAT3     4'h3
`define CRD_CT_SSTEP_CLR 4'h4
`define CRD_CT_SSTEP_SET 4'h5
`endif

// file: pkg/crd_pkg.sv
`default_nettype none
package crd_pkg;
  // Instruction class selected by the third hex digit.
  typedef enum logic [1:0] {
    CRD_C_NONE   = 2'h0,
    CRD_C_LOAD   = 2'h1,
    CRD_C_SENSE  = 2'h3,
    CRD_C_CTL    = 2'h2
  } crd_class_t;
endpackage
`default_nettype wire

// file: hdl/crd_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "crd_cfg.svh"
// Splits an instruction word into class, modifier, byte select and register.
module crd_decode
(
  input  wire logic              [15:0] instr,
  output crd_pkg::crd_class_t           cls,
  output logic                   [3:0]  modifier,
  output logic                          hi_byte,
  output logic                   [2:0]  reg_sel,
  output logic                          is_branch
);

  wire       is_io = (instr[15:12] == `CRD_OP_IO);
  wire [3:0] cdig  = instr[7:4];

  // Class lookup; any other third digit gets no class, and the branch digit is decoded below.
  assign cls = !is_io                   ? crd_pkg::CRD_C_NONE  :
               (cdig == `CRD_CLS_LOAD)  ? crd_pkg::CRD_C_LOAD  :
               (cdig == `CRD_CLS_SENSE) ? crd_pkg::CRD_C_SENSE :
               (cdig == `CRD_CLS_CTL)   ? crd_pkg::CRD_C_CTL   :
                                          crd_pkg::CRD_C_NONE;
  assign modifier  = instr[11:8];
  assign hi_byte   = instr[3];
  assign reg_sel   = instr[2:0];
  // Branch form carries a fixed tail digit instead of byte and register.
  assign is_branch = is_io && (cdig == `CRD_CLS_BRANCH)
                     && (instr[3:0] == `CRD_BR_TAIL);

endmodule // crd_decode
`default_nettype wire

// file: hdl/crd_reader_io.sv
`timescale 1ns/10ps
`default_nettype none
`include "crd_cfg.svh"
module crd_reader_io
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [7:0]  work_register_zero_low,
  input  wire logic [15:0] local_storage_register_data,
  input  wire logic        unit_check,
  input  wire logic        diag_valid,
  input  wire logic [7:0]  ctl_data_byte,
  input  wire logic [7:0]  ctl_status1,
  input  wire logic [7:0]  ctl_status2,
  input  wire logic [7:0]  ctl_status3,
  output logic             selected_r,
  output logic [2:0]       data_register_select_r,
  output logic             byte_hi_r,
  output logic             sense_valid_r,
  output logic [7:0]       sense_byte_r,
  output logic             branch_valid_r,
  output logic             branch_taken_r,
  output logic [7:0]       data_bus_in_r,
  output logic             data_bus_in_load_r,
  output logic             diag_mode_r,
  output logic             irq_pending_r,
  output logic             irq_enable_r,
  output logic             sys_irq_r,
  output logic             single_cycle_r
);

  crd_pkg::crd_class_t cls;
  logic [3:0]          modifier;
  logic                hi_byte;
  logic [2:0]          reg_sel;
  logic                is_branch;

  // Field extraction lives apart so the decode can be reused.
  crd_decode u_decode
  (
    .instr     (instr),
    .cls       (cls),
    .modifier  (modifier),
    .hi_byte   (hi_byte),
    .reg_sel   (reg_sel),
    .is_branch (is_branch)
  );

  // Only instructions for our selector value act; register and byte select follow every word.
  wire sel = instr_valid && (work_register_zero_low == `CRD_DEV_SEL);

  // Picks the byte of the chosen local storage register.
  function automatic logic [7:0] pick_byte(input logic [15:0] w,
                                           input logic        hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  wire [7:0] reg_byte = pick_byte(local_storage_register_data,
                                  hi_byte);

  wire is_ld = sel && (cls == crd_pkg::CRD_C_LOAD);
  wire is_sn = sel && (cls == crd_pkg::CRD_C_SENSE);
  wire is_ct = sel && (cls == crd_pkg::CRD_C_CTL);
  wire is_br = sel && is_branch;

  // Branch condition table; other modifiers never branch.
  wire br_cond =
    (modifier == `CRD_BR_UCHK)     ?  unit_check :
    (modifier == `CRD_BR_NO_UCHK)  ? !unit_check :
    (modifier == `CRD_BR_DIAG_OK)  ?  diag_valid :
    (modifier == `CRD_BR_DIAG_BAD) ? !diag_valid : 1'b0;

  // Sense byte selection; unassigned modifiers read zero without effect.
  wire sn_known = (modifier == `CRD_SN_DATA) || (modifier == `CRD_SN_STAT1)
                  || (modifier == `CRD_SN_STAT2)
                  || (modifier == `CRD_SN_STAT3);
  wire [7:0] sn_byte =
    (modifier == `CRD_SN_DATA)  ? ctl_data_byte :
    (modifier == `CRD_SN_STAT1) ? ctl_status1   :
    (modifier == `CRD_SN_STAT2) ? ctl_status2   :
    (modifier == `CRD_SN_STAT3) ? ctl_status3   : 8'h00;

  // Latch updates; every unlisted modifier keeps the old value.
  wire ld_diag_set  = is_ld && (modifier == `CRD_LD_DIAG_SET);
  wire ld_diag_clr  = is_ld && (modifier == `CRD_LD_DIAG_CLR);
  wire ld_irq_clr   = is_ld && (modifier == `CRD_LD_IRQ_CLR);
  wire ld_irq_set   = is_ld && (modifier == `CRD_LD_IRQ_SET);
  wire ld_bus_in    = is_ld && (modifier == `CRD_LD_BUS_IN);
  wire ld_irq_block = is_ld && (modifier == `CRD_LD_IRQ_BLOCK);
  wire ld_irq_allow = is_ld && (modifier == `CRD_LD_IRQ_ALLOW);
  wire ct_ss_clr    = is_ct && (modifier == `CRD_CT_SSTEP_CLR);
  wire ct_ss_set    = is_ct && (modifier == `CRD_CT_SSTEP_SET);

  wire diag_nxt = ld_diag_set ? 1'b1 :
                  ld_diag_clr ? 1'b0 : diag_mode_r;
  wire irq_p_nxt = ld_irq_set ? 1'b1 :
                   ld_irq_clr ? 1'b0 : irq_pending_r;
  wire irq_e_nxt = ld_irq_allow ? 1'b1 :
                   ld_irq_block ? 1'b0 : irq_enable_r;
  wire ss_nxt = ct_ss_set ? 1'b1 :
                ct_ss_clr ? 1'b0 : single_cycle_r;

  // Answer registers for the processor side.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      selected_r             <= 1'b0;
      data_register_select_r <= 3'h0;
      byte_hi_r              <= 1'b0;
      sense_valid_r          <= 1'b0;
      sense_byte_r           <= 8'h00;
      branch_valid_r         <= 1'b0;
      branch_taken_r         <= 1'b0;
    end
    else
    begin
      selected_r             <= sel;
      data_register_select_r <= reg_sel;
      byte_hi_r              <= hi_byte;
      sense_valid_r          <= is_sn && sn_known;
      sense_byte_r           <= is_sn ? sn_byte : 8'h00;
      branch_valid_r         <= is_br;
      branch_taken_r         <= is_br && br_cond;
    end
  end

  // Attachment latches and the data-bus-in buffer.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      data_bus_in_r      <= 8'h00;
      data_bus_in_load_r <= 1'b0;
      diag_mode_r        <= 1'b0;
      irq_pending_r      <= 1'b0;
      irq_enable_r       <= 1'b0;
      sys_irq_r          <= 1'b0;
      single_cycle_r     <= 1'b0;
    end
    else
    begin
      if (ld_bus_in)
        data_bus_in_r <= reg_byte;
      data_bus_in_load_r <= ld_bus_in;
      diag_mode_r        <= diag_nxt;
      irq_pending_r      <= irq_p_nxt;
      irq_enable_r       <= irq_e_nxt;
      // Request is only presented while presentation is permitted.
      sys_irq_r          <= irq_p_nxt && irq_e_nxt;
      single_cycle_r     <= ss_nxt;
    end
  end

  a_foreign_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    instr_valid && (work_register_zero_low != `CRD_DEV_SEL) |=>
      $stable(irq_pending_r) && $stable(single_cycle_r)
      && !branch_valid_r && !sense_valid_r)
    else $error("Foreign selector changed state.");

  a_bus_in_byte: assert property (@(posedge ref_clk) disable iff (reset)
    ld_bus_in |=> data_bus_in_load_r
      && data_bus_in_r == $past(reg_byte))
    else $error("Wrong byte loaded into data bus in.");

  a_reg_select: assert property (@(posedge ref_clk) disable iff (reset)
    sel |=> data_register_select_r == $past(instr[2:0]))
    else $error("Register select mismatch.");

  a_branch_form: assert property (@(posedge ref_clk) disable iff (reset)
    branch_valid_r |-> $past(instr[15:12]) == `CRD_OP_IO
      && $past(instr[7:4]) == `CRD_CLS_BRANCH)
    else $error("Branch reported for a non-branch word.");

  a_branch_uchk: assert property (@(posedge ref_clk) disable iff (reset)
    is_br && modifier == `CRD_BR_UCHK |=>
      branch_taken_r == $past(unit_check))
    else $error("Unit check branch wrong.");

  a_irq_set_clr: assert property (@(posedge ref_clk) disable iff (reset)
    (ld_irq_set |=> irq_pending_r) and (ld_irq_clr |=> !irq_pending_r))
    else $error("Interrupt request latch wrong.");

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (reset)
    ld_irq_block |=> !sys_irq_r && !irq_enable_r)
    else $error("Blocked interrupt still presented.");

  a_diag_mode: assert property (@(posedge ref_clk) disable iff (reset)
    ld_diag_set ##1 !ld_diag_clr |=> diag_mode_r)
    else $error("Diagnostic mode lost.");

  a_sense_stat3: assert property (@(posedge ref_clk) disable iff (reset)
    is_sn && modifier == `CRD_SN_STAT3 |=>
      sense_valid_r && sense_byte_r == $past(ctl_status3))
    else $error("Status byte three not returned.");

  a_step_clear: assert property (@(posedge ref_clk) disable iff (reset)
    ct_ss_clr |=> !single_cycle_r)
    else $error("Single cycle not cleared.");

  a_step_set: assert property (@(posedge ref_clk) disable iff (reset)
    ct_ss_set |=> single_cycle_r)
    else $error("Single cycle not set.");

  // Any load code outside the assigned set, including gaps such as 2.
  a_unassigned_ld: assert property (@(posedge ref_clk) disable iff (reset)
    is_ld && !(ld_diag_set || ld_diag_clr || ld_irq_clr || ld_irq_set
      || ld_bus_in || ld_irq_block || ld_irq_allow) |=> $stable(diag_mode_r)
      && $stable(irq_pending_r) && $stable(irq_enable_r)
      && !data_bus_in_load_r)
    else $error("Unassigned load changed state.");

endmodule // crd_reader_io
`default_nettype wire

// file: verif/crd_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the processor's local storage: eight registers holding
// fixed patterns, so the bench can predict every byte without a copy.
module crd_cpu_model
(
  input  wire logic [15:0] instr,
  output logic      [15:0] reg_data
);
  // The register is chosen combinationally from the low three bits, within
  // the instruction cycle, because the block samples it on the same edge.
  assign reg_data = {4'ha, 1'b0, instr[2:0], 4'h5, 1'b0, instr[2:0]};
endmodule // crd_cpu_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "crd_cfg.svh"
module tb;
  logic        ref_clk, reset, instr_valid, unit_check, diag_valid;
  logic [15:0] instr, local_storage_register_data;
  logic [7:0]  work_register_zero_low, ctl_data_byte;
  logic [7:0]  ctl_status1, ctl_status2, ctl_status3, sense_byte_r;
  logic [7:0]  data_bus_in_r;
  logic [2:0]  data_register_select_r;
  logic        selected_r, byte_hi_r, sense_valid_r, branch_valid_r;
  logic        branch_taken_r, data_bus_in_load_r, diag_mode_r;
  logic        irq_pending_r, irq_enable_r, sys_irq_r, single_cycle_r;
  int          bad_count = 0;
  int          samples_checked = 0;

  crd_reader_io dut_u
  (
    .ref_clk, .reset, .instr_valid, .instr, .work_register_zero_low,
    .local_storage_register_data, .unit_check, .diag_valid,
    .ctl_data_byte, .ctl_status1, .ctl_status2, .ctl_status3,
    .selected_r, .data_register_select_r, .byte_hi_r, .sense_valid_r,
    .sense_byte_r, .branch_valid_r, .branch_taken_r, .data_bus_in_r,
    .data_bus_in_load_r, .diag_mode_r, .irq_pending_r, .irq_enable_r,
    .sys_irq_r, .single_cycle_r
  );

  crd_cpu_model cpu_u
  (
    .instr    (instr),
    .reg_data (local_storage_register_data)
  );

  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One instruction pulse; results are looked at just after the answer edge.
  task automatic issue(input logic [3:0] m, input logic [3:0] c,
                       input logic [3:0] lo);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr       <= {`CRD_OP_IO, m, c, lo};
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic t_load;
    issue(`CRD_LD_DIAG_SET, `CRD_CLS_LOAD, 4'h0);
    chk("diag set", diag_mode_r, 1'b1);
    issue(`CRD_LD_DIAG_CLR, `CRD_CLS_LOAD, 4'h0);
    chk("diag clr", diag_mode_r, 1'b0);
    issue(`CRD_LD_IRQ_ALLOW, `CRD_CLS_LOAD, 4'h0);
    chk("irq allow", irq_enable_r, 1'b1);
    issue(`CRD_LD_IRQ_SET, `CRD_CLS_LOAD, 4'h0);
    chk("irq set", {irq_pending_r, sys_irq_r}, 2'h3);
    issue(`CRD_LD_IRQ_BLOCK, `CRD_CLS_LOAD, 4'h0);
    chk("irq block", {irq_enable_r, sys_irq_r}, 2'h0);
    issue(`CRD_LD_IRQ_CLR, `CRD_CLS_LOAD, 4'h0);
    chk("irq clr", irq_pending_r, 1'b0);
    issue(`CRD_LD_BUS_IN, `CRD_CLS_LOAD, 4'hd);
    chk("bus in hi", {data_bus_in_load_r, data_bus_in_r}, 9'h1a5);
    chk("reg hi", {byte_hi_r, data_register_select_r}, 4'hd);
    issue(`CRD_LD_BUS_IN, `CRD_CLS_LOAD, 4'h2);
    chk("bus in lo", data_bus_in_r, 8'h52);
  endtask

  task automatic t_sense;
    logic [7:0] exp [0:3];
    exp = '{ctl_data_byte, ctl_status1, ctl_status2, ctl_status3};
    for (int m = 0; m < 4; m++)
    begin
      issue(m[3:0], `CRD_CLS_SENSE, 4'h0);
      chk("sense", {sense_valid_r, sense_byte_r}, {1'b1, exp[m]});
    end
    issue(4'h5, `CRD_CLS_SENSE, 4'h0);
    chk("sense none", sense_valid_r, 1'b0);
  endtask

  task automatic t_branch;
    for (int v = 0; v < 2; v++)
    begin
      @(posedge ref_clk);
      unit_check <= v[0];
      diag_valid <= v[0];
      issue(`CRD_BR_UCHK, `CRD_CLS_BRANCH, `CRD_BR_TAIL);
      chk("br uchk", {branch_valid_r, branch_taken_r}, {1'b1, v[0]});
      issue(`CRD_BR_NO_UCHK, `CRD_CLS_BRANCH, `CRD_BR_TAIL);
      chk("br no uchk", branch_taken_r, !v[0]);
      issue(`CRD_BR_DIAG_OK, `CRD_CLS_BRANCH, `CRD_BR_TAIL);
      chk("br diag ok", branch_taken_r, v[0]);
      issue(`CRD_BR_DIAG_BAD, `CRD_CLS_BRANCH, `CRD_BR_TAIL);
      chk("br diag bad", branch_taken_r, !v[0]);
    end
    // A modifier outside the table is decoded but never branches.
    issue(4'h2, `CRD_CLS_BRANCH, `CRD_BR_TAIL);
    chk("br unknown", {branch_valid_r, branch_taken_r}, 2'h2);
  endtask

  // Latch set, then foreign selector and unassigned codes must not move it.
  task automatic t_ctl_refuse;
    issue(`CRD_CT_SSTEP_SET, `CRD_CLS_CTL, 4'h0);
    chk("sstep set", single_cycle_r, 1'b1);
    @(posedge ref_clk);
    work_register_zero_low <= 8'h40;
    issue(`CRD_CT_SSTEP_CLR, `CRD_CLS_CTL, 4'h0);
    chk("foreign", {selected_r, single_cycle_r}, 2'h1);
    @(posedge ref_clk);
    work_register_zero_low <= `CRD_DEV_SEL;
    issue(4'h2, `CRD_CLS_LOAD, 4'h1);
    chk("unused ld latch", {diag_mode_r, irq_pending_r}, 2'h0);
    chk("unused bus", {data_bus_in_load_r, data_bus_in_r}, 9'h052);
    issue(4'he, `CRD_CLS_CTL, 4'h1);
    chk("unassigned ct", {selected_r, single_cycle_r}, 2'h3);
    issue(`CRD_CT_SSTEP_CLR, `CRD_CLS_CTL, 4'h0);
    chk("sstep clr", single_cycle_r, 1'b0);
  endtask

  // Latches set, then a mid-run reset must clear every output at once.
  task automatic t_reset;
    issue(`CRD_LD_DIAG_SET, `CRD_CLS_LOAD, 4'h0);
    issue(`CRD_LD_IRQ_ALLOW, `CRD_CLS_LOAD, 4'h0);
    issue(`CRD_CT_SSTEP_SET, `CRD_CLS_CTL, 4'h0);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("rst diag", {diag_mode_r, single_cycle_r}, 2'h0);
    chk("rst irq", {irq_pending_r, irq_enable_r, sys_irq_r}, 3'h0);
    chk("rst byte", {data_bus_in_r, sense_byte_r}, 16'h0000);
    chk("rst sel", {selected_r, byte_hi_r}, 2'h0);
    chk("rst reg", data_register_select_r, 3'h0);
    chk("rst pulse", {sense_valid_r, branch_valid_r}, 2'h0);
    chk("rst br", {branch_taken_r, data_bus_in_load_r}, 2'h0);
    @(posedge ref_clk);
    reset <= 1'b0;
    // Presentation comes back blocked, so a raised request stays hidden.
    issue(`CRD_LD_IRQ_SET, `CRD_CLS_LOAD, 4'h0);
    chk("after rst", {irq_pending_r, sys_irq_r}, 2'h2);
  endtask

  task automatic stop_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence after a ten-cycle reset.
  initial
  begin
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = 16'h0000;
    work_register_zero_low = `CRD_DEV_SEL;
    unit_check = 1'b0;
    diag_valid = 1'b0;
    ctl_data_byte = 8'h3c;
    ctl_status1 = 8'h5a;
    ctl_status2 = 8'h96;
    ctl_status3 = 8'he1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_load();
    t_sense();
    t_branch();
    t_ctl_refuse();
    t_reset();
    stop_test();
  end

  // The tests need under 200 cycles; a hang is cut off well after that.
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end
endmodule // tb
`default_nettype wire
